/* File: pkg/adc_readout_pkg.sv */
// constants shared by the conversion-frame readout core and its serial shifter
package adc_readout_pkg;

  // channel count and result word width
  localparam int NCH_DEF       = 6;
  localparam int WORD_W_DEF    = 24;

  // conversion period at 4 kSPS, ratio 1024, high resolution, global chop
  localparam int CLK_PERIOD_NS = 50;      // core_clk at 20 MHz
  localparam int CONV_TIME_NS  = 754000;  // 0.754 ms
  localparam int CONV_CYCLES_DEF = CONV_TIME_NS / CLK_PERIOD_NS;

  // result queue fill levels
  localparam logic [1:0] LVL_EMPTY = 2'h0;
  localparam logic [1:0] LVL_ONE   = 2'h1;
  localparam logic [1:0] LVL_FULL  = 2'h2;

  // status word field positions (first word of every frame)
  localparam int ST_LEVEL_LSB   = 0;
  localparam int ST_LEVEL_W     = 2;
  localparam int ST_OVF_BIT     = 14;
  localparam int ST_REALIGN_BIT = 15;

  // reset levels of the pin synchronisers
  localparam logic [1:0] SYNC_IDLE_HI = 2'h3;
  localparam logic [1:0] SYNC_IDLE_LO = 2'h0;

endpackage

/* File: hw/frame_shifter.sv */
// serial-clock side of the readout: shifts one frame out on the data pin
`timescale 1ns/1ns
`default_nettype none

module frame_shifter #(
  parameter int FRAME_W = 168,
  parameter int IDX_W   = 8
) (
  // link clock and frame select
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               rst_n,
  // frame image, held steady by the core while selected
  input  wire logic [FRAME_W-1:0] frame_in,
  // serial data pin
  output logic                    sdo,
  output logic                    sdo_oe,
  // level: whole frame shifted, until deselect
  output logic                    frame_done
);
  import adc_readout_pkg::*;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic             sdo;
    logic             done;
  } shift_t;

  shift_t r;
  shift_t n;
  logic   clr;

  // deselect ends the frame; the link clock may stop, so no edge is needed
  assign clr = cs_n | ~rst_n;

  // next bit and completion tracking
  always_comb begin
    n = r;
    if (r.idx < IDX_W'(FRAME_W)) begin
      n.sdo = frame_in[IDX_W'(FRAME_W - 1) - r.idx];
      n.idx = r.idx + IDX_W'(1);
    end else begin
      n.sdo = 1'b0;
    end
    // completion set on the same edge that drives the last bit
    if (r.idx == IDX_W'(FRAME_W - 1)) begin
      n.done = 1'b1;
    end
  end

  // data changes on the rising edge, host samples on the falling edge
  always_ff @(posedge sclk or posedge clr) begin
    if (clr) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // released pin whenever deselected, so other devices can share the line
  assign sdo_oe     = ~cs_n;
  assign sdo        = r.sdo;
  assign frame_done = r.done;

endmodule // frame_shifter

`default_nettype wire

/* File: hw/adc_frame_readout_sync.sv */
// conversion timing, two-deep result queue, alignment check and frame readout
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - the serial data pin is released whenever chip select is high.
// - results queue two deep, and an overflow makes ready fall only every third period.
// - a result is consumed only after a whole frame is shifted, else it is sent again.
// - a sync pulse out of step with the period sets the realign flag even after a clear.
// - the sync input checks period alignment and restarts the period timer, but never forces a result.
// - one conversion takes 0.754 ms at the documented high-resolution settings.
// - aligned devices on one clock convert together, so one ready pin suffices.
module adc_frame_readout_sync #(
  parameter int NCH         = adc_readout_pkg::NCH_DEF,
  parameter int WORD_W      = adc_readout_pkg::WORD_W_DEF,
  parameter int CONV_CYCLES = adc_readout_pkg::CONV_CYCLES_DEF
) (
  // core clock, reset, enable
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  // results from the converter path, same clock
  input  wire logic [NCH*WORD_W-1:0] sample_data,
  // sync pin, asynchronous
  input  wire logic                  sync_reset_n,
  // serial port
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  output logic                       sdo,
  output logic                       sdo_oe,
  // status pins
  output logic                       result_ready_n,
  output logic                       realign_flag,
  output logic                       fifo_overflow,
  output logic                       conv_tick
);
  import adc_readout_pkg::*;

  localparam int FRAME_W = (NCH + 1) * WORD_W;
  localparam int IDX_W   = $clog2(FRAME_W + 1);
  localparam int TMR_W   = $clog2(CONV_CYCLES + 1);
  localparam int DATA_W  = NCH * WORD_W;

  typedef struct packed {
    logic [TMR_W-1:0]         tmr;
    logic [1:0]               level;
    logic [1:0][DATA_W-1:0]   fifo;
    logic [FRAME_W-1:0]       frame;
    logic                     rdy_n;
    logic                     realign;
    logic                     ovf;
    logic                     tick;
    logic [1:0]               sync_ff;
    logic                     sync_prev;
    logic [1:0]               cs_ff;
    logic [1:0]               done_ff;
    logic                     done_prev;
  } core_t;

  core_t              r;
  core_t              n;
  logic               frame_done;
  logic               tick;
  logic               sync_rise;
  logic               pop;
  logic [1:0]         lvl;
  logic [WORD_W-1:0]  status;

  // link-side shifter; the frame image is quasi-static while selected
  frame_shifter #(
    .FRAME_W (FRAME_W),
    .IDX_W   (IDX_W)
  ) u_shift (
    .sclk       (sclk),
    .cs_n       (cs_n),
    .rst_n      (rst_n),
    .frame_in   (r.frame),
    .sdo        (sdo),
    .sdo_oe     (sdo_oe),
    .frame_done (frame_done)
  );

  // next-state logic for the whole core
  always_comb begin
    n      = r;
    lvl    = r.level;
    status = '0;

    // two-flop synchronisers; only the second stage is looked at
    n.sync_ff   = {r.sync_ff[0], sync_reset_n};
    n.sync_prev = r.sync_ff[1];
    n.cs_ff     = {r.cs_ff[0], cs_n};
    n.done_ff   = {r.done_ff[0], frame_done};
    n.done_prev = r.done_ff[1];

    // conversion period timer, free running
    tick  = (r.tmr == TMR_W'(CONV_CYCLES - 1));
    n.tmr = tick ? '0 : r.tmr + TMR_W'(1);

    // a frame is consumed only when the shifter saw every bit
    pop = r.done_ff[1] & ~r.done_prev & (r.level != LVL_EMPTY);
    if (pop) begin
      n.fifo[0] = r.fifo[1];
      lvl       = r.level - 2'h1;
      n.realign = 1'b0;
      n.ovf     = 1'b0;
    end

    // new result; an unread full queue is flushed, so ready skips a period
    if (tick) begin
      if (lvl == LVL_FULL) begin
        lvl   = LVL_EMPTY;
        n.ovf = 1'b1;
      end else begin
        n.fifo[lvl[0]] = sample_data;
        lvl            = lvl + 2'h1;
      end
    end
    n.level = lvl;
    n.tick  = tick;

    // sync release checks the period edge and restarts the period timer; it never forces a result
    sync_rise = r.sync_ff[1] & ~r.sync_prev;
    if (sync_rise) begin
      n.tmr = '0;
      // out-of-step pulse flags, set after the read clear so it wins
      if (!tick) begin
        n.realign = 1'b1;
      end
    end

    // ready low while a result waits, high for a cycle after each read
    n.rdy_n = (lvl == LVL_EMPTY) | pop;

    // frame image refreshed only while deselected, never mid-frame
    status[ST_LEVEL_LSB +: ST_LEVEL_W] = n.level;
    status[ST_OVF_BIT]                 = n.ovf;
    status[ST_REALIGN_BIT]             = n.realign;
    if (r.cs_ff[1]) begin
      n.frame = {status, n.fifo[0]};
    end
  end

  // state register; enable low freezes everything
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r         <= '0;
      r.rdy_n   <= 1'b1;
      r.sync_ff <= SYNC_IDLE_HI;
      r.sync_prev <= 1'b1;
      r.cs_ff   <= SYNC_IDLE_HI;
      r.done_ff <= SYNC_IDLE_LO;
    end else if (ce) begin
      r <= n;
    end
  end

  // status outputs straight from flops
  assign result_ready_n = r.rdy_n;
  assign realign_flag   = r.realign;
  assign fifo_overflow  = r.ovf;
  assign conv_tick      = r.tick;

endmodule // adc_frame_readout_sync

`default_nettype wire

/* File: verif/adc_readout_properties.sv */
// concurrent checks on the readout core pins
`timescale 1ns/1ns
`default_nettype none
module adc_readout_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins watched
  input wire logic cs_n,
  input wire logic sdo_oe,
  input wire logic sync_reset_n,
  input wire logic result_ready_n,
  input wire logic realign_flag,
  input wire logic fifo_overflow,
  input wire logic conv_tick
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // sync release while idle and clear of any period end
  sequence quiet_sync;
    $rose(sync_reset_n) ##1 (cs_n && !conv_tick)[*7];
  endsequence
  a_release_when_idle: assert property (cs_n |-> !sdo_oe)
    else $error("pin driven while idle");
  a_overflow_flush: assert property ($rose(fifo_overflow) |-> conv_tick && result_ready_n)
    else $error("bad flush");
  a_ready_stays: assert property (cs_n[*4] ##0 (!result_ready_n && !conv_tick)
    |=> !result_ready_n || fifo_overflow)
    else $error("result lost unread");
  a_flag_holds: assert property (cs_n[*4] ##0 realign_flag |=> realign_flag)
    else $error("flag lost");
  a_sync_sets_flag: assert property (quiet_sync |-> realign_flag)
    else $error("flag not set");
  a_sync_no_start: assert property (
    $rose(sync_reset_n) ##1 (!conv_tick)[*5] |=> (!conv_tick)[*5])
    else $error("sync started a period");
  a_tick_spacing: assert property (conv_tick |=> (!conv_tick)[*8])
    else $error("period too short");
  a_ready_after_tick: assert property (conv_tick && !fifo_overflow |-> !result_ready_n)
    else $error("ready missing");
endmodule // adc_readout_properties
bind adc_frame_readout_sync adc_readout_properties adc_readout_properties_inst (.core_clk,
  .rst_n, .cs_n, .sdo_oe, .sync_reset_n, .result_ready_n, .realign_flag, .fifo_overflow,
  .conv_tick);
`default_nettype wire

/* File: verif/spi_host.sv */
// host serial master model
`timescale 1ns/1ns
`default_nettype none
module spi_host (
  // serial port
  output logic      sclk,
  output logic      cs_n,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic [167:0] rx;
  // clock still outside frames; released pin reads inverse of last bit
  task automatic xfer(input int nbits);
    rx = '0;
    // select stays a per-frame strobe; it is never tied low, so no data crc is needed
    #200 cs_n = 1'h0;
    for (int i = 0; i < nbits; i++) begin
      #62 sclk = 1'h1;
      #63 sclk = 1'h0;
      rx = {rx[166:0], sdo_oe ? sdo : ~rx[0]};
    end
    #200 cs_n = 1'h1;
    #200;
  endtask
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
  end
endmodule // spi_host
`default_nettype wire

/* File: verif/adc_frame_readout_sync_bench.sv */
// self-checking bench for the frame readout core
`timescale 1ns/1ns
`default_nettype none
module adc_frame_readout_sync_bench;
  localparam logic [143:0] D1 = {6{24'h5A3C96}};
  logic core_clk, rst_n, ce, sync_reset_n, sclk, cs_n, sdo, sdo_oe;
  logic result_ready_n, realign_flag, fifo_overflow, conv_tick;
  logic [143:0] sample_data;
  int err_count, samples_checked, cyc;
  adc_frame_readout_sync #(.CONV_CYCLES(1000)) adc_frame_readout_sync_inst (.core_clk, .rst_n,
    .ce, .sample_data, .sync_reset_n, .sclk, .cs_n, .sdo, .sdo_oe, .result_ready_n,
    .realign_flag, .fifo_overflow, .conv_tick);
  spi_host spi_host_inst (.sclk, .cs_n, .sdo, .sdo_oe);
  task automatic check(input logic [167:0] seen, input logic [167:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_tick();
    do @(negedge core_clk); while (conv_tick !== 1'h1);
  endtask
  // out-of-step sync pulse, well inside a period; one shared pulse aligns a group
  task automatic pulse_sync();
    sync_reset_n = 1'h0;
    repeat (4) @(negedge core_clk);
    sync_reset_n = 1'h1;
    repeat (10) @(negedge core_clk);
  endtask
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  // cut a hang short; the run needs about 7600 cycles; the count only tracks core clock cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    sync_reset_n = 1'h1;
    sample_data = D1;
    repeat (6) @(negedge core_clk);
    rst_n = 1'h1;
    @(negedge core_clk);
    check({result_ready_n, realign_flag, fifo_overflow, sdo_oe}, 4'h8);
    $display("test 1 end");
    wait_tick();
    check(result_ready_n, 1'h0);
    sample_data = ~D1;
    spi_host_inst.xfer(168);
    check(spi_host_inst.rx, {24'h000001, D1});
    check(result_ready_n, 1'h1);
    $display("test 2 end");
    wait_tick();
    spi_host_inst.xfer(40);
    check(result_ready_n, 1'h0);
    spi_host_inst.xfer(168);
    check(spi_host_inst.rx, {24'h000001, ~D1});
    $display("test 3 end");
    repeat (3) wait_tick();
    check({result_ready_n, fifo_overflow}, 2'h3);
    wait_tick();
    check(result_ready_n, 1'h0);
    $display("test 4 end");
    pulse_sync();
    check(realign_flag, 1'h1);
    spi_host_inst.xfer(168);
    check(spi_host_inst.rx, {24'h00C001, ~D1});
    check({realign_flag, fifo_overflow}, 2'h0);
    pulse_sync();
    check(realign_flag, 1'h1);
    $display("test 5 end");
    // enable low must freeze the period timer past a whole period
    ce = 1'h0;
    repeat (1100) begin
      @(negedge core_clk);
      check({conv_tick, realign_flag}, 2'h1);
    end
    ce = 1'h1;
    $display("test 6 end");
    summarize();
  end
endmodule // adc_frame_readout_sync_bench
`default_nettype wire
